// ---- logic/pdw_pkg.sv ----
// Shared constants and carrier types for the packet descriptor walker
`default_nettype none
package pdw_pkg;
  // ------------------------------------------------------------
  // Descriptor layout
  // ------------------------------------------------------------
  localparam int unsigned         WORD_COUNT      = 4;          // Words per descriptor
  localparam logic [1:0]          WORD_NEXT       = 2'h0;       // Next pointer word
  localparam logic [1:0]          WORD_BUF        = 2'h1;       // Buffer pointer word
  localparam logic [1:0]          WORD_OFFLEN     = 2'h2;       // Offset and length word
  localparam logic [1:0]          WORD_FLAGS      = 2'h3;       // Flags and packet length word
  localparam logic [31:0]         WORD_STRIDE     = 32'h4;      // Bytes per word
  localparam logic [31:0]         NULL_PTR        = 32'h0;      // End of chain marker
  localparam int unsigned         FIRST_BIT       = 31;         // packet_first_flag
  localparam int unsigned         LAST_BIT        = 30;         // packet_last_flag
  localparam int unsigned         OWNS_BIT        = 29;         // engine_owns_flag
  localparam int unsigned         HALF_HI         = 16;         // Upper half start

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  // One decoded descriptor handed to the data mover
  typedef struct packed {
    logic [31:0] desc_addr;     // Address of this descriptor
    logic [31:0] buf_addr;      // First valid byte (start plus offset when filled)
    logic [15:0] buf_len;       // Valid bytes or capacity
    logic [15:0] pkt_len;       // Total length, zero unless a filled first fragment
    logic        first;         // Packet begins here
    logic        last;          // Packet ends here
  } pdw_job_type;

  // Walker states
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_CHECK, ST_ISSUE, ST_WAIT, ST_PATCH
  } pdw_state_type;
endpackage : pdw_pkg
`default_nettype wire

// ---- logic/pdw_skid.sv ----
// Two-entry buffer between the walker and the data mover
`default_nettype none
module pdw_skid #(
  parameter int unsigned WIDTH = 98  // Payload width
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [WIDTH-1:0] mem_reg [2];   // Two entries
  logic [WIDTH-1:0] mem_next [2];  // Next entries
  logic             wp_reg, wp_next; // Write slot
  logic             rp_reg, rp_next; // Read slot
  logic [1:0]       cnt_reg, cnt_next; // Occupancy
  logic             push, pop;     // Transfers this cycle

  // Full and empty straight from the count, so a stalled drain backs up
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next-state of pointers, count and entries
  always_comb begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wp_reg] = in_data;
      wp_next          = ~wp_reg;
    end
    if (pop) begin
      rp_next = ~rp_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  // Register stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end
endmodule : pdw_skid
`default_nettype wire

// ---- logic/pdw_walker.sv ----
// Descriptor chain walker: fetches, checks ownership, issues jobs, patches back
//
// Operation
// - Word 0 links to the next descriptor
// - Word 1 is the data buffer address
// - Word 2 upper half: offset when filled
// - Word 2 lower half: bytes or capacity
// - Word 3: flags high, packet length low
// - First flag marks packet start
// - Last flag ends the packet
// - Packet length used only on filled starts
// - Zero next pointer ends the list
// - Ownership checked only at packet start
// - Clear ownership on start descriptor afterwards
`default_nettype none
module pdw_walker #(
  parameter int unsigned AW = 32  // Address width of the memory bus
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Chain start
  input  wire logic                 start_valid,   // Begin walking at start_addr
  input  wire logic [31:0]          start_addr,
  input  wire logic                 buf_filled,    // Buffers hold data (transmit)
  output logic                      busy,          // Walk in progress
  output logic                      at_end,        // Stopped on zero next pointer
  // Memory bus
  output logic                      mem_req,       // Request, held until mem_ack
  output logic                      mem_we,
  output logic [AW-1:0]             mem_addr,
  output logic [31:0]               mem_wdata,
  input  wire logic                 mem_ack,       // Accepts request, read data valid
  input  wire logic [31:0]          mem_rdata,
  // Job stream to the data mover
  output logic                      job_valid,
  input  wire logic                 job_ready,
  output pdw_pkg::pdw_job_type      job_data,
  input  wire logic                 job_done       // Pulse: one job finished
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  pdw_pkg::pdw_state_type st_reg, st_next;     // Walker state
  logic [31:0] cur_reg, cur_next;              // Current descriptor address
  logic [31:0] sop_reg, sop_next;              // Packet-start descriptor address
  logic [31:0] sopw3_reg, sopw3_next;          // Packet-start flags word
  logic [31:0] w_reg [4];                      // Fetched words
  logic [31:0] w_next [4];
  logic [1:0]  idx_reg, idx_next;              // Word being fetched
  logic        own_reg, own_next;              // Packet owned by engine
  logic [1:0]  pend_reg, pend_next;            // Jobs not yet done
  logic        end_reg, end_next;              // List end reached
  logic        q_valid, q_ready;               // Buffer filling side
  pdw_pkg::pdw_job_type q_data;

  // Flag decoding, used only on the fetched words in w_reg
  function automatic logic flag(input logic [31:0] w, input int unsigned b);
    flag = w[b];
  endfunction : flag

  // ------------------------------------------------------------
  // Job formation
  // ------------------------------------------------------------
  always_comb begin
    q_data.desc_addr = cur_reg;
    q_data.buf_addr  = w_reg[pdw_pkg::WORD_BUF];
    if (buf_filled) begin
      q_data.buf_addr = w_reg[pdw_pkg::WORD_BUF]
                        + {16'h0, w_reg[pdw_pkg::WORD_OFFLEN][31:pdw_pkg::HALF_HI]};
    end
    q_data.buf_len = w_reg[pdw_pkg::WORD_OFFLEN][pdw_pkg::HALF_HI-1:0];
    q_data.first   = flag(w_reg[pdw_pkg::WORD_FLAGS], pdw_pkg::FIRST_BIT);
    q_data.last    = flag(w_reg[pdw_pkg::WORD_FLAGS], pdw_pkg::LAST_BIT);
    q_data.pkt_len = 16'h0;
    if (q_data.first && buf_filled) begin
      q_data.pkt_len = w_reg[pdw_pkg::WORD_FLAGS][pdw_pkg::HALF_HI-1:0];
    end
  end

  // Hold back a push while the pending count is full, so long packets cannot wrap it
  assign q_valid = (st_reg == pdw_pkg::ST_ISSUE) && (pend_reg != '1);

  // Two-entry buffer: a stalled mover holds the walker in ST_ISSUE
  pdw_skid #(.WIDTH($bits(pdw_pkg::pdw_job_type))) u_skid (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (q_valid),
    .in_ready  (q_ready),
    .in_data   (q_data),
    .out_valid (job_valid),
    .out_ready (job_ready),
    .out_data  (job_data)
  );

  // ------------------------------------------------------------
  // Walker next-state
  // ------------------------------------------------------------
  always_comb begin
    st_next   = st_reg;
    cur_next  = cur_reg;
    sop_next  = sop_reg;
    sopw3_next = sopw3_reg;
    w_next    = w_reg;
    idx_next  = idx_reg;
    own_next  = own_reg;
    end_next  = end_reg;
    pend_next = pend_reg;
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = cur_reg[AW-1:0];
    mem_wdata = 32'h0;
    // Completions may arrive in any state
    if (job_done && pend_reg != 2'h0) begin
      pend_next = pend_reg - 2'h1;
    end
    unique case (st_reg)
      pdw_pkg::ST_IDLE: begin
        if (start_valid) begin
          cur_next = start_addr;
          idx_next = pdw_pkg::WORD_NEXT;
          end_next = 1'b0;
          st_next  = (start_addr == pdw_pkg::NULL_PTR) ? pdw_pkg::ST_IDLE
                                                       : pdw_pkg::ST_READ;
        end
      end
      pdw_pkg::ST_READ: begin
        // Consecutive word reads, 0 to 3, before any use
        mem_req  = 1'b1;
        mem_addr = AW'(cur_reg + ({30'h0, idx_reg} * pdw_pkg::WORD_STRIDE));
        if (mem_ack) begin
          w_next[idx_reg] = mem_rdata;
          idx_next        = idx_reg + 2'h1;
          if (idx_reg == pdw_pkg::WORD_FLAGS) begin
            st_next = pdw_pkg::ST_CHECK;
          end
        end
      end
      pdw_pkg::ST_CHECK: begin
        // Ownership only read at packet start; later fragments inherit it
        if (flag(w_reg[pdw_pkg::WORD_FLAGS], pdw_pkg::FIRST_BIT)) begin
          own_next   = flag(w_reg[pdw_pkg::WORD_FLAGS], pdw_pkg::OWNS_BIT);
          sop_next   = cur_reg;
          sopw3_next = w_reg[pdw_pkg::WORD_FLAGS];
          if (flag(w_reg[pdw_pkg::WORD_FLAGS], pdw_pkg::OWNS_BIT)) begin
            st_next = pdw_pkg::ST_ISSUE;
          end else begin
            st_next = pdw_pkg::ST_IDLE;
          end
        end else begin
          st_next = own_reg ? pdw_pkg::ST_ISSUE : pdw_pkg::ST_IDLE;
        end
      end
      pdw_pkg::ST_ISSUE: begin
        if (q_valid && q_ready) begin
          pend_next = pend_next + 2'h1;
          if (flag(w_reg[pdw_pkg::WORD_FLAGS], pdw_pkg::LAST_BIT)) begin
            st_next = pdw_pkg::ST_WAIT;
          end else if (w_reg[pdw_pkg::WORD_NEXT] == pdw_pkg::NULL_PTR) begin
            end_next = 1'b1;
            st_next  = pdw_pkg::ST_IDLE;
          end else begin
            cur_next = w_reg[pdw_pkg::WORD_NEXT];
            idx_next = pdw_pkg::WORD_NEXT;
            st_next  = pdw_pkg::ST_READ;
          end
        end
      end
      pdw_pkg::ST_WAIT: begin
        // Patch only once every fragment of the packet is done
        if (pend_next == 2'h0) begin
          st_next = pdw_pkg::ST_PATCH;
        end
      end
      pdw_pkg::ST_PATCH: begin
        mem_req   = 1'b1;
        mem_we    = 1'b1;
        mem_addr  = AW'(sop_reg + ({30'h0, pdw_pkg::WORD_FLAGS} * pdw_pkg::WORD_STRIDE));
        mem_wdata = sopw3_reg & ~(32'h1 << pdw_pkg::OWNS_BIT);
        if (mem_ack) begin
          own_next = 1'b0;
          if (w_reg[pdw_pkg::WORD_NEXT] == pdw_pkg::NULL_PTR) begin
            end_next = 1'b1;
            st_next  = pdw_pkg::ST_IDLE;
          end else begin
            cur_next = w_reg[pdw_pkg::WORD_NEXT];
            idx_next = pdw_pkg::WORD_NEXT;
            st_next  = pdw_pkg::ST_READ;
          end
        end
      end
    endcase
  end

  // Register stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg    <= pdw_pkg::ST_IDLE;
      cur_reg   <= 32'h0;
      sop_reg   <= 32'h0;
      sopw3_reg <= 32'h0;
      idx_reg   <= 2'h0;
      own_reg   <= 1'b0;
      end_reg   <= 1'b0;
      pend_reg  <= 2'h0;
    end else begin
      st_reg    <= st_next;
      cur_reg   <= cur_next;
      sop_reg   <= sop_next;
      sopw3_reg <= sopw3_next;
      idx_reg   <= idx_next;
      own_reg   <= own_next;
      end_reg   <= end_next;
      pend_reg  <= pend_next;
    end
    w_reg <= w_next;
  end

  assign busy   = (st_reg != pdw_pkg::ST_IDLE);
  assign at_end = end_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_FETCH_ORDER: assert property (
      (st_reg == pdw_pkg::ST_READ && mem_ack && idx_reg != pdw_pkg::WORD_FLAGS) |=>
      st_reg == pdw_pkg::ST_READ && idx_reg == $past(idx_reg) + 2'h1)
    else $error("Descriptor words not fetched in order");
  AST_READ_ADDR: assert property (
      st_reg == pdw_pkg::ST_READ |->
      mem_addr == AW'(cur_reg + {28'h0, idx_reg, 2'h0}) && !mem_we)
    else $error("Descriptor read address wrong");
  AST_FOLLOW_NEXT: assert property (
      (q_valid && q_ready && !q_data.last && w_reg[0] != 32'h0) |=>
      cur_reg == $past(w_reg[0]))
    else $error("Next pointer not followed");
  AST_NULL_END: assert property (
      (q_valid && q_ready && !q_data.last && w_reg[0] == 32'h0) |=>
      st_reg == pdw_pkg::ST_IDLE && at_end)
    else $error("Zero next pointer did not end the list");
  AST_NOT_OWNED: assert property (
      (st_reg == pdw_pkg::ST_CHECK && q_data.first && !w_reg[3][pdw_pkg::OWNS_BIT]) |=>
      st_reg == pdw_pkg::ST_IDLE)
    else $error("Unowned packet was processed");
  AST_PATCH_CLEAR: assert property (
      (mem_req && mem_we) |->
      !mem_wdata[pdw_pkg::OWNS_BIT] && mem_addr == AW'(sop_reg + 32'hc))
    else $error("Patch does not clear ownership at start descriptor");
  AST_LAST_PATCH: assert property (
      (q_valid && q_ready && q_data.last) |=> st_reg == pdw_pkg::ST_WAIT)
    else $error("Last fragment did not lead to patch");
  AST_PKT_LEN: assert property (
      (q_valid && !(q_data.first && buf_filled)) |-> q_data.pkt_len == 16'h0)
    else $error("Packet length passed on a non-start descriptor");
  AST_OFFSET: assert property (
      (q_valid && buf_filled) |->
      q_data.buf_addr == w_reg[1] + {16'h0, w_reg[2][31:16]})
    else $error("Offset not applied to filled buffer");

  COV_SINGLE: cover property (q_valid && q_ready && q_data.first && q_data.last);
  COV_MULTI: cover property (q_valid && q_ready && !q_data.first && q_data.last);
  COV_STALL: cover property (q_valid && !q_ready);
  COV_PATCH: cover property (mem_req && mem_we && mem_ack);
endmodule : pdw_walker
`default_nettype wire

// ---- verif/pdw_mem_model.sv ----
// Memory model that holds descriptor lists and answers the walker's bus
`default_nettype none
module pdw_mem_model (
  // Clock, reset and answer latency
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  lat,
  // Memory bus
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [31:0] mem [0:255];  // Word store, byte address bits 9:2
  logic [3:0]  wait_cnt;     // Cycles spent on the current request

  // Ack after lat idle cycles; read data flips outside the ack so stale use shows
  always @(posedge ref_clk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      wait_cnt  <= 4'h0;
      mem_rdata <= 32'h0f0f0f0f;
    end else if (mem_req && !mem_ack) begin
      if (wait_cnt >= lat) begin
        wait_cnt <= 4'h0;
        mem_ack  <= 1'b1;
        if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
        else mem_rdata <= mem[mem_addr[9:2]];
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : pdw_mem_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench for the descriptor walker
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic                 ref_clk, rst, start_valid, buf_filled, busy, at_end;
  logic                 mem_req, mem_we, mem_ack, job_valid, job_ready, job_done;
  logic [31:0]          start_addr, mem_addr, mem_wdata, mem_rdata, rd_base;
  logic [3:0]           lat;
  pdw_pkg::pdw_job_type job_data;
  pdw_pkg::pdw_job_type exp_q[$];    // Jobs expected, in chain order
  logic [31:0]          exp_w3 [0:4]; // Flags words expected afterwards
  integer seed = 90545, bad_count = 0, compares = 0, pend = 0, rdn = 0, stall = 0;

  pdw_walker i_pdw_walker (.ref_clk(ref_clk), .rst(rst), .start_valid(start_valid),
    .start_addr(start_addr), .buf_filled(buf_filled), .busy(busy), .at_end(at_end),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .job_valid(job_valid),
    .job_ready(job_ready), .job_data(job_data), .job_done(job_done));
  pdw_mem_model mm (.ref_clk(ref_clk), .rst(rst), .lat(lat), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [97:0] seen, input logic [97:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Five descriptors at 0x100: single, three fragments, single; zero ends it
  task automatic build(input logic own_a);
    logic [2:0]  fl [0:4];
    logic [31:0] r;
    integer      b;
    fl = '{3'h7, 3'h5, 3'h1, 3'h2, 3'h7};  // B2 engine_owns_flag bit must be ignored
    for (int i = 0; i < 5; i++) begin
      b = 32'h40 + 4 * i;
      r = $random(seed);
      mm.mem[b]     = (i == 4) ? 32'h0 : 32'h100 + 16 * (i + 1);
      mm.mem[b + 1] = $random(seed);
      mm.mem[b + 2] = $random(seed);
      mm.mem[b + 3] = {fl[i], r[28:0]};
    end
    if (!own_a) mm.mem[32'h43][29] = 1'b0;
  endtask : build

  // Walk the list as the engine should and queue what it must hand out
  task automatic expect_walk(input logic filled, output logic exp_end);
    pdw_pkg::pdw_job_type j;
    logic [31:0] d, w3;
    integer      b, sop;
    logic        open;
    d = 32'h100;
    open = 1'b0;
    sop = 0;
    exp_end = 1'b0;
    exp_q.delete();
    for (int k = 0; k < 5; k++) exp_w3[k] = mm.mem[32'h43 + 4 * k];
    for (int k = 0; k < 5; k++) begin
      if (d == 32'h0) break;
      b = d[9:2];
      w3 = mm.mem[b + 3];
      if (!open && !(w3[31] && w3[29])) break;
      if (w3[31]) begin
        sop = k;
        open = 1'b1;
      end
      j.desc_addr = d;
      j.buf_addr = filled ? mm.mem[b + 1] + {16'h0, mm.mem[b + 2][31:16]} : mm.mem[b + 1];
      j.buf_len = mm.mem[b + 2][15:0];
      j.pkt_len = (w3[31] && filled) ? w3[15:0] : 16'h0;
      j.first = w3[31];
      j.last = w3[30];
      exp_q.push_back(j);
      if (w3[30]) begin
        exp_w3[sop][29] = 1'b0;
        open = 1'b0;
      end
      exp_end = (mm.mem[b] == 32'h0);
      d = mm.mem[b];
    end
  endtask : expect_walk

  task automatic run(input string name, input logic filled, input logic [3:0] lt,
                     input integer stl);
    logic exp_end;
    expect_walk(filled, exp_end);
    stall = stl;
    @(posedge ref_clk);
    buf_filled <= filled;
    lat <= lt;
    start_valid <= 1'b1;
    start_addr <= 32'h100;
    @(posedge ref_clk);
    start_valid <= 1'b0;
    #1;
    for (int n = 0; n < 3000 && (busy !== 1'b0 || job_valid !== 1'b0); n++) begin
      @(posedge ref_clk);
      #1;
    end
    check("walk_done", {busy, job_valid}, 2'h0);
    check("at_end", at_end, exp_end);
    check("jobs_left", exp_q.size(), 0);
    for (int k = 0; k < 5; k++) check("flags_word", mm.mem[32'h43 + 4 * k], exp_w3[k]);
    $display("test %s done", name);
  endtask : run

  // --------------------------------------------------------------
  // Data mover: random stalls, one done per accepted job, later
  // --------------------------------------------------------------
  always @(posedge ref_clk) begin
    job_done <= 1'b0;
    if (rst) begin
      pend = 0;
    end else begin
      if (job_valid && job_ready) begin
        if (exp_q.size() == 0) check("job_extra", 1, 0);
        else check("job", job_data, exp_q.pop_front());
        pend++;
      end
      if (pend > 0 && ($random(seed) & 3) == 0) begin
        job_done <= 1'b1;
        pend--;
      end
    end
    if (stall > 0) stall--;
    job_ready <= (stall == 0) && ($random(seed) & 1);
  end

  // Descriptor reads come as four words in order from the descriptor
  always @(posedge ref_clk) begin
    if (rst) begin
      rdn = 0;
    end else if (mem_req && mem_ack) begin
      if (mem_we) begin
        check("patch_word", mem_addr[3:0], 4'hc);
      end else begin
        if (rdn == 0) rd_base = mem_addr;
        check("fetch_addr", mem_addr, rd_base + 4 * rdn);
        rdn = (rdn + 1) % 4;
      end
    end
  end

  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst = 1'b1;
    start_valid = 1'b0;
    start_addr = 32'h0;
    buf_filled = 1'b1;
    lat = 4'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    build(1'b1);
    run("chain_filled", 1'b1, 4'h0, 0);
    build(1'b1);
    run("chain_empty_stalled", 1'b0, 4'h3, 60);
    build(1'b0);
    run("unowned_start", 1'b1, 4'h1, 0);
    @(posedge ref_clk);
    start_valid <= 1'b1;
    start_addr <= 32'h0;
    @(posedge ref_clk);
    start_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("zero_start_busy", busy, 1'b0);
    $display("test zero_start done");
    build(1'b1);
    mm.mem[32'h44] = 32'h0;
    run("cut_chain", 1'b1, 4'h2, 0);
    for (int t = 0; t < 4; t++) begin
      build(1'b1);
      run("random_chain", $random(seed) & 1, $random(seed) & 7, $random(seed) & 31);
    end
    finish_test();
  end
endmodule : testbench
`default_nettype wire
